// ### verilog/ppg_defines.svh
// Contract
// R1 - Shared base, paired modes: phase shifts both
// R2 - Shared base, independent mode: phase low only
// R3 - Local base: phase register is period; code keeps high output on master period in independent mode
// R4 - Pulse width clamped 0x0008 to period-0x0008
// R5 - Secondary phase used only independent mode
// R6 - Dead-time registers 14 bits, top zero
// R7 - Divider N outputs every N+1 event
// R8 - Dual-trigger bit merges secondary into primary
// R9 - Start delay waits N PWM cycles
// R10 - Secondary trigger never raises interrupt
// R11 - Ownership bit selects PWM or GPIO
// R12 - Polarity bit makes pin active-low
// R13 - Mode field encodes four pair modes
// R14 - Override enable drives pin from data
// R15 - Normal fault forces fault state bits
// R16 - Independent fault: limit high, fault low
// R17 - Normal limit forces limit state bits
// R18 - Forced states pass through polarity
// R19 - Swap bit exchanges high and low
// R20 - Software changes modes only while disabled
// R21 - Time base select picks local period; in independent mode code picks it for low output only
// R22 - Override sync applies data at boundary
`ifndef PPG_DEFINES_SVH
`define PPG_DEFINES_SVH
`define PPG_A_PHASE     3'h0
`define PPG_A_SPHASE    3'h1
`define PPG_A_DT        3'h2
`define PPG_A_ALTDT     3'h3
`define PPG_A_TRIG      3'h4
`define PPG_A_IOCTL     3'h5
`define PPG_A_CTRL      3'h6
`define PPG_A_STAT      3'h7
`define PPG_DT_MASK     16'h3FFF
`define PPG_TRIG_MASK   16'hF0BF
`define PPG_MIN_PULSE   16'h0008
`define PPG_RESET_VAL   16'h0000
`define PPG_TG_DIV_HI   15
`define PPG_TG_DIV_LO   12
`define PPG_TG_DUAL     7
`define PPG_IO_HIGH_PIN_OWNER     15
`define PPG_IO_LOW_PIN_OWNER     14
`define PPG_IO_HIGH_PIN_POLARITY     13
`define PPG_IO_POLL     12
`define PPG_IO_MODE_HI  11
`define PPG_IO_MODE_LO  10
`define PPG_IO_OVH      9
`define PPG_IO_OVL      8
`define PPG_IO_OVD_HI   7
`define PPG_IO_OVD_LO   6
`define PPG_IO_FLT_HI   5
`define PPG_IO_FLT_LO   4
`define PPG_IO_CL_HI    3
`define PPG_IO_CL_LO    2
`define PPG_IO_SWAP     1
`define PPG_IO_OVERRIDE_SYNC    0
`define PPG_CT_EN       0
`define PPG_CT_ITB      1
`define PPG_CT_IFLT     2
`define PPG_CT_TRGIE    3
`endif

// ### verilog/ppg_pkg.sv
package ppg_pkg;
    typedef enum logic [1:0] {
        PPG_COMPL  = 2'b00,
        PPG_REDUND = 2'b01,
        PPG_PUSHPL = 2'b10,
        PPG_INDEP  = 2'b11
    } ppg_mode_t;
    typedef enum logic [0:0] {
        PPG_WAIT = 1'b0,
        PPG_RUN  = 1'b1
    } ppg_tstate_t;
    typedef struct packed {
        logic [15:0] phase;
        logic [15:0] sphase;
        logic [15:0] dtPri;
        logic [15:0] dtAlt;
        logic [15:0] trig;
        logic [15:0] ioctl;
        logic [3:0]  ctrl;
        logic [1:0]  ovdActive;
        logic [15:0] rdata;
        ppg_tstate_t tstate;
        logic [5:0]  startCnt;
        logic [3:0]  priCnt;
        logic [3:0]  secCnt;
        logic        trigPri;
        logic        trigSec;
        logic        trigIrq;
        logic        pinH;
        logic        pinL;
        logic        ownH;
        logic        ownL;
        logic [15:0] hPhase;
        logic [15:0] lPhase;
        logic [15:0] hPeriod;
        logic [15:0] lPeriod;
        logic        hLocal;
        logic        lLocal;
        logic [15:0] dutyMin;
        logic [15:0] dutyMaxH;
    } ppg_state_t;
endpackage

// ### verilog/ppg_pair_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppg_defines.svh"
module ppg_pair_config
    import ppg_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [2:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output var  logic [15:0] regRdata,
    input  wire logic [15:0] masterPeriod,
    input  wire logic        cycleStart,
    input  wire logic        priEvent,
    input  wire logic        secEvent,
    input  wire logic        genHigh,
    input  wire logic        genLow,
    input  wire logic        faultActive,
    input  wire logic        limitActive,
    output var  logic        trigPrimary,
    output var  logic        trigSecondary,
    output var  logic        trigIrqReq,
    output var  logic        highOutput,
    output var  logic        lowOutput,
    output var  logic        highOwnedByPwm,
    output var  logic        lowOwnedByPwm,
    output var  logic [15:0] highPhase,
    output var  logic [15:0] lowPhase,
    output var  logic [15:0] highPeriod,
    output var  logic [15:0] lowPeriod,
    output var  logic        highLocalBase,
    output var  logic        lowLocalBase,
    output var  logic [15:0] minPulse,
    output var  logic [15:0] maxPulse
);

    ppg_state_t st_reg;
    ppg_state_t st_next;

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------

    // Divider match: count reaches field value
    function automatic logic divHit(input logic [3:0] cnt,
                                    input logic [3:0] div);
        divHit = (cnt == div); // [R7]
    endfunction

    // Next divider count, wrapping after the field value
    function automatic logic [3:0] divStep(input logic [3:0] cnt,
                                           input logic [3:0] div);
        divStep = (cnt == div) ? 4'h0 : cnt + 4'h1; // [R7]
    endfunction

    // Forced level as active/inactive then polarity applied
    function automatic logic polar(input logic lvl,
                                   input logic pol);
        polar = lvl ^ pol; // [R12] [R18]
    endfunction

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------

    logic [3:0]  divN;
    logic        dual;
    logic        enable;
    logic        independent_time_base_select;
    logic        ifltMode;
    ppg_mode_t   mode;
    logic        sigH;
    logic        sigL;
    logic        actH;
    logic        actL;
    logic        high_pin_polarity;
    logic        polL;
    logic        priOk;
    logic        secOk;

    always_comb
    begin
        st_next  = st_reg;

        // Fields decoded from the configuration words
        divN     = st_reg.trig[`PPG_TG_DIV_HI:`PPG_TG_DIV_LO];
        dual     = st_reg.trig[`PPG_TG_DUAL];
        enable   = st_reg.ctrl[`PPG_CT_EN];
        independent_time_base_select      = st_reg.ctrl[`PPG_CT_ITB]; // [R21]
        ifltMode = st_reg.ctrl[`PPG_CT_IFLT];
        mode     = ppg_mode_t'(
            st_reg.ioctl[`PPG_IO_MODE_HI:`PPG_IO_MODE_LO]); // [R13]
        high_pin_polarity     = st_reg.ioctl[`PPG_IO_HIGH_PIN_POLARITY];
        polL     = st_reg.ioctl[`PPG_IO_POLL];
        priOk    = 1'b0;
        secOk    = 1'b0;

        // Register writes; reserved bits kept at zero
        if (regWrite)
        begin
            case (regAddr)
                `PPG_A_PHASE:  st_next.phase  = regWdata;
                `PPG_A_SPHASE: st_next.sphase = regWdata;
                `PPG_A_DT:     st_next.dtPri  = regWdata & `PPG_DT_MASK; // [R6]
                `PPG_A_ALTDT:  st_next.dtAlt  = regWdata & `PPG_DT_MASK; // [R6]
                `PPG_A_TRIG:   st_next.trig   = regWdata & `PPG_TRIG_MASK;
                `PPG_A_IOCTL:  st_next.ioctl  = regWdata;
                `PPG_A_CTRL:   st_next.ctrl   = regWdata[3:0];
                default:       st_next.ctrl   = st_reg.ctrl;
            endcase
        end

        // Read data, valid in the cycle after the strobe
        st_next.rdata = 16'h0000;
        if (regRead)
        begin
            case (regAddr)
                `PPG_A_PHASE:  st_next.rdata = st_reg.phase;
                `PPG_A_SPHASE: st_next.rdata = st_reg.sphase;
                `PPG_A_DT:     st_next.rdata = st_reg.dtPri;
                `PPG_A_ALTDT:  st_next.rdata = st_reg.dtAlt;
                `PPG_A_TRIG:   st_next.rdata = st_reg.trig;
                `PPG_A_IOCTL:  st_next.rdata = st_reg.ioctl;
                `PPG_A_CTRL:   st_next.rdata = {12'h000, st_reg.ctrl};
                `PPG_A_STAT:   st_next.rdata = {10'h000, st_reg.startCnt};
                default:       st_next.rdata = 16'h0000;
            endcase
        end

        // Override data: immediate, or held until cycle boundary
        if (!st_reg.ioctl[`PPG_IO_OVERRIDE_SYNC] || cycleStart)
        begin
            st_next.ovdActive =
                st_reg.ioctl[`PPG_IO_OVD_HI:`PPG_IO_OVD_LO]; // [R22]
        end

        // Trigger start delay and postscalers
        st_next.trigPri = 1'b0;
        st_next.trigSec = 1'b0;
        st_next.trigIrq = 1'b0;
        if (!enable)
        begin
            st_next.tstate   = PPG_WAIT;
            st_next.startCnt = st_reg.trig[5:0];
            st_next.priCnt   = 4'h0;
            st_next.secCnt   = 4'h0;
        end
        else
        begin
            case (st_reg.tstate)
                PPG_WAIT:
                begin
                    if (st_reg.startCnt == 6'h00)
                    begin
                        st_next.tstate = PPG_RUN; // [R9]
                    end
                    else if (cycleStart)
                    begin
                        st_next.startCnt = st_reg.startCnt - 6'h01; // [R9]
                    end
                end
                PPG_RUN:
                begin
                    if (priEvent)
                    begin
                        priOk = divHit(st_reg.priCnt, divN);
                        st_next.priCnt = divStep(st_reg.priCnt, divN);
                    end
                    if (secEvent)
                    begin
                        secOk = divHit(st_reg.secCnt, divN);
                        st_next.secCnt = divStep(st_reg.secCnt, divN);
                    end

                    // Merge the streams or keep two separate triggers
                    if (dual)
                    begin
                        st_next.trigPri = priOk | secOk; // [R8]
                    end
                    else
                    begin
                        st_next.trigPri = priOk; // [R8]
                        st_next.trigSec = secOk;
                    end

                    // Only primary events may ask for the interrupt
                    st_next.trigIrq = priOk
                        & st_reg.ctrl[`PPG_CT_TRGIE]; // [R10]
                end
                default: st_next.tstate = PPG_WAIT;
            endcase
        end

        // Phase and period routing per base and mode
        st_next.hLocal = independent_time_base_select; // [R21]
        st_next.lLocal = independent_time_base_select;
        if (!independent_time_base_select)
        begin
            st_next.hPeriod = masterPeriod;
            st_next.lPeriod = masterPeriod;
            if (mode == PPG_INDEP)
            begin
                st_next.hPhase = 16'h0000;
                st_next.lPhase = st_reg.phase; // [R2] [R5]
            end
            else
            begin
                st_next.hPhase = st_reg.phase; // [R1]
                st_next.lPhase = st_reg.phase; // [R1] [R5]
            end
        end
        else
        begin
            st_next.hPhase = 16'h0000;
            st_next.lPhase = 16'h0000;
            st_next.lPeriod = st_reg.phase; // [R3]
            if (mode == PPG_INDEP)
            begin
                st_next.hPeriod = masterPeriod;
                st_next.hLocal  = 1'b0;
                st_next.lPhase  = st_reg.sphase; // [R5]
            end
            else
            begin
                st_next.hPeriod = st_reg.phase; // [R3]
            end
        end

        // Upper pulse limit follows the high output's own period; lower is fixed
        st_next.dutyMin  = `PPG_MIN_PULSE; // [R4]
        st_next.dutyMaxH = st_next.hPeriod - `PPG_MIN_PULSE; // [R4]

        // Output stage: swap, override, forcing, then pin polarity
        sigH = genHigh;
        sigL = genLow;
        actH = 1'b0;
        actL = 1'b0;

        // Swap first, so every later step acts on the pins
        if (st_reg.ioctl[`PPG_IO_SWAP])
        begin
            sigH = genLow; // [R19]
            sigL = genHigh; // [R19]
        end

        // Override data per pin, as an active or inactive level
        if (st_reg.ioctl[`PPG_IO_OVH])
        begin
            sigH = st_reg.ovdActive[1]; // [R14]
        end
        if (st_reg.ioctl[`PPG_IO_OVL])
        begin
            sigL = st_reg.ovdActive[0]; // [R14]
        end

        // Fault and limit forcing take priority over override
        if (ifltMode)
        begin
            if (limitActive)
            begin
                sigH = st_reg.ioctl[`PPG_IO_FLT_HI]; // [R16] [R17]
            end
            if (faultActive)
            begin
                sigL = st_reg.ioctl[`PPG_IO_FLT_LO]; // [R16]
            end
        end
        else if (faultActive)
        begin
            sigH = st_reg.ioctl[`PPG_IO_FLT_HI]; // [R15]
            sigL = st_reg.ioctl[`PPG_IO_FLT_LO]; // [R15]
        end
        else if (limitActive)
        begin
            sigH = st_reg.ioctl[`PPG_IO_CL_HI]; // [R17]
            sigL = st_reg.ioctl[`PPG_IO_CL_LO]; // [R17]
        end

        // Pin polarity last, so forced states stay active levels
        actH = polar(sigH, high_pin_polarity); // [R12] [R18]
        actL = polar(sigL, polL); // [R12] [R18]
        st_next.pinH = actH;
        st_next.pinL = actL;

        // Pin ownership: PWM logic or general-purpose I/O
        st_next.ownH = st_reg.ioctl[`PPG_IO_HIGH_PIN_OWNER]; // [R11]
        st_next.ownL = st_reg.ioctl[`PPG_IO_LOW_PIN_OWNER]; // [R11]
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------

    // All state cleared on power-on reset
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------

    // Register port read data, straight from the state register
    assign regRdata       = st_reg.rdata;

    // Trigger pulses toward the converter and interrupt logic
    assign trigPrimary    = st_reg.trigPri;
    assign trigSecondary  = st_reg.trigSec;
    assign trigIrqReq     = st_reg.trigIrq;

    // Pin levels and pin ownership
    assign highOutput     = st_reg.pinH;
    assign lowOutput      = st_reg.pinL;
    assign highOwnedByPwm = st_reg.ownH;
    assign lowOwnedByPwm  = st_reg.ownL;

    // Phase, period and pulse limits for the generator
    assign highPhase      = st_reg.hPhase;
    assign lowPhase       = st_reg.lPhase;
    assign highPeriod     = st_reg.hPeriod;
    assign lowPeriod      = st_reg.lPeriod;
    assign highLocalBase  = st_reg.hLocal;
    assign lowLocalBase   = st_reg.lLocal;
    assign minPulse       = st_reg.dutyMin;
    assign maxPulse       = st_reg.dutyMaxH;

endmodule
`default_nettype wire

// ### verif/ppg_power_stage.sv
`timescale 1ns/1ps
`default_nettype none
module ppg_power_stage (
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic fltCmd,
    input  wire logic limCmd,
    input  wire logic slow,
    output logic      faultActive,
    output logic      limitActive
);
    logic [1:0] fltPipe;
    logic [1:0] limPipe;

    // Sensing path, answers one or two cycles late
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fltPipe <= 2'b00;
            limPipe <= 2'b00;
        end
        else
        begin
            fltPipe <= {fltPipe[0], fltCmd};
            limPipe <= {limPipe[0], limCmd};
        end
    end

    // Slow stage reports from the second tap
    assign faultActive = slow ? fltPipe[1] : fltPipe[0];
    assign limitActive = slow ? limPipe[1] : limPipe[0];
endmodule
`default_nettype wire

// ### verif/ppg_pair_config_props.sv
`timescale 1ns/1ps
`default_nettype none
module ppg_pair_config_props (
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic [2:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [15:0] regRdata,
    input wire logic [15:0] masterPeriod,
    input wire logic        priEvent,
    input wire logic        secEvent,
    input wire logic        trigPrimary,
    input wire logic        trigSecondary,
    input wire logic        trigIrqReq,
    input wire logic        highOwnedByPwm,
    input wire logic [15:0] highPeriod,
    input wire logic        highLocalBase,
    input wire logic        lowLocalBase,
    input wire logic [15:0] minPulse
);
    logic ownBit;
    logic ioWrite;

    // Ownership bit of a write to the pin control word
    assign ownBit = regWdata[15];
    assign ioWrite = regWrite && regAddr == 3'h5;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Output relations
    a_dead_top_zero: assert property ($past(regRead) &&
        $past(regAddr) inside {3'h2, 3'h3} |-> regRdata[15:14] == 2'b00)
        else $error("dead-time top bits not zero");
    a_high_owner: assert property (ioWrite ##1 !ioWrite [*2]
        |-> highOwnedByPwm == $past(ownBit, 2))
        else $error("high pin owner wrong");
    a_min_pulse: assert property ($past(arst_n)
        |-> minPulse == 16'h0008)
        else $error("minimum pulse wrong");
    a_irq_primary: assert property (trigIrqReq |-> trigPrimary)
        else $error("interrupt without primary trigger");
    a_trig_cause: assert property (trigPrimary
        |-> $past(priEvent) || $past(secEvent))
        else $error("primary trigger without event");
    a_sec_cause: assert property (trigSecondary |-> $past(secEvent))
        else $error("secondary trigger without event");
    a_local_pair: assert property (highLocalBase |-> lowLocalBase)
        else $error("high local base without low");
    a_shared_period: assert property ($past(arst_n, 2) &&
        !highLocalBase |-> highPeriod == $past(masterPeriod))
        else $error("shared period not routed");
endmodule
bind ppg_pair_config ppg_pair_config_props u_props (.clock, .arst_n,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .masterPeriod,
    .priEvent, .secEvent, .trigPrimary, .trigSecondary, .trigIrqReq,
    .highOwnedByPwm, .highPeriod, .highLocalBase, .lowLocalBase, .minPulse);
`default_nettype wire

// ### verif/ppg_pair_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppg_defines.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    failures++; $display("ERROR %0t got %h want %h", $time, got, exp); \
    end end
module ppg_pair_config_bench;
    logic        clock, arst_n, regWrite, regRead, cycleStart, priEvent;
    logic        secEvent, genHigh, genLow, fltCmd, limCmd, slow;
    logic        trigPrimary, trigSecondary, trigIrqReq, highOutput;
    logic        lowOutput, highOwnedByPwm, lowOwnedByPwm, faultActive;
    logic        highLocalBase, lowLocalBase, limitActive;
    logic        rdLate = 1'b0;
    logic [2:0]  regAddr;
    logic [15:0] regWdata, masterPeriod, regRdata, highPhase, lowPhase;
    logic [15:0] highPeriod, lowPeriod, minPulse, maxPulse, p, s, d, want;
    logic [15:0] rdQ[$];
    int          failures, checks, cycles, seed, nPri, nSec, nIrq, b0, b1, b2;

    ppg_pair_config dut_u (.clock, .arst_n, .regAddr, .regWdata,
        .regWrite, .regRead, .regRdata, .masterPeriod, .cycleStart,
        .priEvent, .secEvent, .genHigh, .genLow, .faultActive,
        .limitActive, .trigPrimary, .trigSecondary, .trigIrqReq,
        .highOutput, .lowOutput, .highOwnedByPwm, .lowOwnedByPwm,
        .highPhase, .lowPhase, .highPeriod, .lowPeriod, .highLocalBase,
        .lowLocalBase, .minPulse, .maxPulse);
    ppg_power_stage u_stage (.clock, .arst_n, .fltCmd, .limCmd, .slow,
        .faultActive, .limitActive);

    // Clock generation
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Result watcher: trigger counts, read data, hang limit
    always @(posedge clock)
    begin
        cycles++;
        if (trigPrimary === 1'b1) nPri++;
        if (trigSecondary === 1'b1) nSec++;
        if (trigIrqReq === 1'b1) nIrq++;
        if (rdLate)
        begin
            want = rdQ.pop_front();
            `CHK(regRdata, want)
        end
        rdLate <= regRead;
        if (cycles > 20000)
        begin
            failures++;
            test_done();
        end
    end

    task automatic test_done();
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tk(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(logic [2:0] a, logic [15:0] v);
        @(posedge clock);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    task automatic rd(logic [2:0] a, logic [15:0] e);
        @(posedge clock);
        rdQ.push_back(e);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
    endtask

    task automatic ev(logic pe, logic se, logic cs);
        @(posedge clock);
        priEvent <= pe;
        secEvent <= se;
        cycleStart <= cs;
        @(posedge clock);
        priEvent <= 1'b0;
        secEvent <= 1'b0;
        cycleStart <= 1'b0;
    endtask

    // Pair settings change only with the module stopped
    task automatic cfg(logic [15:0] io, logic [3:0] ct);
        wr(`PPG_A_CTRL, 16'h0000);
        wr(`PPG_A_IOCTL, io);
        wr(`PPG_A_CTRL, {12'h000, ct});
        tk(3);
    endtask

    // Main sequence
    initial
    begin
        seed = 87;
        {regWrite, regRead, cycleStart, priEvent, secEvent} = 5'h00;
        {genHigh, genLow, fltCmd, limCmd, slow} = 5'h00;
        regAddr = 3'h0;
        regWdata = 16'h0000;
        masterPeriod = 16'($random(seed));
        arst_n = 1'b0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        for (int a = 0; a < 6; a++) rd(a[2:0], 16'h0000);
        for (int i = 0; i < 18; i++)
        begin
            d = 16'($random(seed));
            b0 = i % 6;
            wr(b0[2:0], d);
            rd(b0[2:0], b0 == 4 ? d & `PPG_TRIG_MASK
                : b0 inside {2, 3} ? d & `PPG_DT_MASK : d);
        end
        p = 16'($random(seed));
        s = 16'($random(seed));
        wr(`PPG_A_PHASE, p);
        wr(`PPG_A_SPHASE, s);
        for (int k = 0; k < 8; k++)
        begin
            cfg({4'hC, k[1:0], 10'h000}, {2'b00, k[2], 1'b0});
            d = (k[2] && k[1:0] != 2'b11) ? p : masterPeriod;
            `CHK(highPeriod, d)
            `CHK(lowPeriod, k[2] ? p : masterPeriod)
            `CHK(highLocalBase, k[2] && k[1:0] != 2'b11)
            `CHK(lowLocalBase, k[2])
            `CHK(minPulse, `PPG_MIN_PULSE)
            `CHK(maxPulse, d - `PPG_MIN_PULSE)
            if (!k[2]) `CHK(lowPhase, p)
            if (!k[2] && k[1:0] != 2'b11) `CHK(highPhase, p)
            if (k == 7) `CHK(lowPhase, s)
            if (k == 3) `CHK(highPhase, 16'h0000)
        end
        for (int k = 0; k < 16; k++)
        begin
            b0 = $random(seed);
            genHigh <= b0[0];
            genLow <= b0[1];
            b1 = k[3] & ~k[1];
            cfg({b0[3:2], k[1:0], 2'b00, b1[0], 1'b0, b0[5:4], 4'h0,
                k[2], 1'b0}, 4'h0);
            `CHK(highOwnedByPwm, b0[3])
            `CHK(lowOwnedByPwm, b0[2])
            `CHK(highOutput, b1 ? b0[5] : b0[k[2]] ^ k[1])
            `CHK(lowOutput, b0[!k[2]] ^ k[0])
        end
        for (int k = 0; k < 4; k++)
        begin
            cfg(16'hD024, {1'b0, k[1], 2'b00});
            fltCmd <= !k[0];
            limCmd <= k[0];
            slow <= k[1];
            tk(4);
            `CHK(highOutput, k[1] ? (k[0] | genHigh) : !k[0])
            `CHK(lowOutput, !(k[1] ? k[0] & genLow : k[0]))
            fltCmd <= 1'b0;
            limCmd <= 1'b0;
        end
        // Synchronised override waits for the cycle boundary
        cfg(16'hC281, 4'h0);
        `CHK(highOutput, 1'b0)
        ev(1'b0, 1'b0, 1'b1);
        tk(2);
        `CHK(highOutput, 1'b1)
        for (int n = 0; n < 16; n++)
        begin
            wr(`PPG_A_TRIG, {n[3:0], 12'h000});
            wr(`PPG_A_CTRL, 16'h0009);
            b0 = nPri;
            b1 = nIrq;
            repeat (3 * n + 2) ev(1'b1, 1'b0, 1'b0);
            tk(2);
            `CHK(nPri - b0, 2)
            `CHK(nIrq - b1, 2)
            wr(`PPG_A_CTRL, 16'h0000);
        end
        for (int m = 0; m < 2; m++)
        begin
            wr(`PPG_A_TRIG, {8'h00, m[0], 7'h00});
            wr(`PPG_A_CTRL, 16'h0009);
            b0 = nSec;
            b1 = nIrq;
            b2 = nPri;
            repeat (3) ev(1'b0, 1'b1, 1'b0);
            tk(2);
            `CHK(nSec - b0, m ? 0 : 3)
            `CHK(nPri - b2, m ? 3 : 0)
            `CHK(nIrq - b1, 0)
            wr(`PPG_A_CTRL, 16'h0000);
        end
        for (int j = 0; j < 2; j++)
        begin
            b1 = j ? 63 : 3;
            wr(`PPG_A_TRIG, {10'h000, b1[5:0]});
            wr(`PPG_A_CTRL, 16'h0001);
            b0 = nPri;
            ev(1'b1, 1'b0, 1'b0);
            repeat (b1 - 1) ev(1'b0, 1'b0, 1'b1);
            ev(1'b1, 1'b0, 1'b0);
            ev(1'b0, 1'b0, 1'b1);
            tk(3);
            ev(1'b1, 1'b0, 1'b0);
            tk(2);
            `CHK(nPri - b0, 1)
            wr(`PPG_A_CTRL, 16'h0000);
        end
        tk(2);
        test_done();
    end
endmodule
`default_nettype wire
